/* hw/cmpe_pkg.sv */
// cmpe_pkg: register map, field positions, reset values and timing for the
// dual comparator event block.
// assumes a 10 MHz system clock and 8-bit register data.
`default_nettype none
package cmpe_pkg;
    localparam int DW = 8;
    localparam int AW = 4;
    // register offsets
    localparam logic [AW-1:0] ADR_CTRL1 = 4'h0; // cmp1_control_reg
    localparam logic [AW-1:0] ADR_CTRL2 = 4'h1; // cmp2_control_reg
    localparam logic [AW-1:0] ADR_DET1 = 4'h2;  // detect_control_reg_one
    localparam logic [AW-1:0] ADR_DET2 = 4'h3;  // detect_control_reg_two
    localparam logic [AW-1:0] ADR_SRC = 4'h4;   // input_source_reg
    localparam logic [AW-1:0] ADR_EDGE = 4'h5;  // edge_select_reg
    localparam logic [AW-1:0] ADR_MODE = 4'h6;  // comparator_mode_reg
    localparam logic [AW-1:0] ADR_PIN = 4'h7;   // pin_select_reg_four
    localparam logic [AW-1:0] ADR_CLK1 = 4'h8;  // system_clock_reg_one
    localparam logic [AW-1:0] ADR_IC1 = 4'h9;   // comparator_int_control_reg, cmp1
    localparam logic [AW-1:0] ADR_IC2 = 4'ha;   // comparator_int_control_reg, cmp2
    localparam logic [AW-1:0] ADR_REF = 4'hb;   // reference select
    // control register fields
    localparam int CB_IEN = 0;
    localparam int CB_FDIS = 1;
    localparam int CB_FLAG = 2;
    localparam int CB_B3 = 3;   // cmp1: result monitor, cmp2: watchdog flag
    localparam int CB_DIV = 4;  // two bits, 5:4
    localparam int CB_DIR = 7;
    // other fields
    localparam int DET1_MON2 = 3;
    localparam int DET2_EN1 = 6;
    localparam int DET2_EN2 = 7;
    localparam int SRC_CMP1 = 5;
    localparam int SRC_CMP2 = 6;
    localparam int EDGE_BOTH1 = 1;
    localparam int EDGE_BOTH2 = 2;
    localparam int MODE_POL1 = 0;
    localparam int MODE_POL2 = 1;
    localparam int MODE_OE1 = 2;
    localparam int MODE_OE2 = 3;
    localparam int MODE_SEL1 = 4;
    localparam int MODE_SEL2 = 5;
    localparam int PIN_COMP = 0;
    localparam int CLK_OSC_STOP = 4;
    localparam int IC_REQ = 3;
    localparam int REF_EXT = 0;
    // writable masks and reset values
    localparam logic [DW-1:0] MODE_MASK = 8'h3f;
    localparam logic [DW-1:0] RST_CTRL = 8'h02;
    localparam logic [DW-1:0] RST_ZERO = 8'h00;
    localparam logic [DW-1:0] RST_CLK1 = 8'h10;
    localparam logic [DW-1:0] FLAG_MASK1 = 8'h04;
    localparam logic [DW-1:0] FLAG_MASK2 = 8'h0c;
    // timing
    localparam int CLK_NS = 100;
    localparam int SETTLE_NS = 100000;  // enable settling delay, least time
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int FILT_DEPTH = 3;

    // sampling clock select code to terminal count of the divider
    function automatic logic [2:0] cmpe_div_limit(input logic [1:0] code);
        unique case (code)
            2'h0: cmpe_div_limit = 3'h0;
            2'h1: cmpe_div_limit = 3'h1;
            2'h2: cmpe_div_limit = 3'h3;
            default: cmpe_div_limit = 3'h7;
        endcase
    endfunction : cmpe_div_limit
endpackage : cmpe_pkg
`default_nettype wire

/* hw/cmpe_chan_if.sv */
// cmpe_chan_if: configuration and event lines between the control core
// and one comparator event channel. all signals on the system clock.
`default_nettype none
interface cmpe_chan_if;
    logic cmp_sync;
    logic tick;
    logic filt_dis;
    logic edge_both;
    logic edge_dir;
    logic armed;
    logic event_p;
    logic filt_val;
    modport ctl (output cmp_sync, tick, filt_dis, edge_both, edge_dir, armed,
                 input event_p, filt_val);
    modport chan (input cmp_sync, tick, filt_dis, edge_both, edge_dir, armed,
                  output event_p, filt_val);
endinterface : cmpe_chan_if
`default_nettype wire

/* hw/cmpe_tick.sv */
// cmpe_tick: sampling clock tick from the low-speed oscillator pin.
// assumes the oscillator is far slower than clk; its input is synchronised here.
`default_nettype none
module cmpe_tick
    import cmpe_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic osc_raw,
    input wire logic run,
    input wire logic [1:0] div_sel,
    output logic tick
);
    logic s1_r, s2_r, s3_r;
    logic [2:0] cnt_r, cnt_nxt;
    logic osc_rise;

    // divide by 1/2/4/8 on oscillator rising edges
    always_comb begin
        osc_rise = s2_r & ~s3_r;
        cnt_nxt = cnt_r;
        tick = 1'b0;
        if (!run) begin
            cnt_nxt = 3'h0;
        end else if (osc_rise) begin
            if (cnt_r >= cmpe_div_limit(div_sel)) begin
                cnt_nxt = 3'h0;
                tick = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 3'h1;
            end
        end
    end

    // two-stage synchroniser then edge history
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            cnt_r <= 3'h0;
        end else if (ce) begin
            s1_r <= osc_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            cnt_r <= cnt_nxt;
        end
    end

    property p_tick_div8;
        @(posedge clk) disable iff (reset)
        ce && tick && run && div_sel == 2'h3 |-> $past(cnt_r) == 3'h7;
    endproperty
    a_tick_div8: assert property (p_tick_div8) else $error("divide by 8 tick early");
endmodule : cmpe_tick
`default_nettype wire

/* hw/cmpe_chan.sv */
// cmpe_chan: digital filter and edge detection for one comparator.
// assumes cmp_sync is already synchronised to clk.
`default_nettype none
module cmpe_chan
    import cmpe_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    cmpe_chan_if.chan ch
);
    logic [FILT_DEPTH-1:0] samp_r, samp_nxt;
    logic filt_r, filt_nxt;
    logic prev_r, cur;
    logic rise, fall;

    // filter takes a new level only when every sample agrees
    always_comb begin
        samp_nxt = samp_r;
        filt_nxt = filt_r;
        if (ch.tick) begin
            samp_nxt = {samp_r[FILT_DEPTH-2:0], ch.cmp_sync};
            if (&samp_nxt || ~|samp_nxt) begin
                filt_nxt = samp_nxt[0];
            end
        end
    end

    // edge condition on filtered or direct level
    always_comb begin
        cur = ch.filt_dis ? ch.cmp_sync : filt_r;
        rise = cur & ~prev_r;
        fall = ~cur & prev_r;
        ch.event_p = ch.armed & (ch.edge_both ? (rise | fall) : (ch.edge_dir ? fall : rise));
        ch.filt_val = filt_r;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            samp_r <= '0;
            filt_r <= 1'b0;
            prev_r <= 1'b0;
        end else if (ce) begin
            samp_r <= samp_nxt;
            filt_r <= filt_nxt;
            prev_r <= cur;
        end
    end

    property p_nofilt_rise;
        @(posedge clk) disable iff (reset)
        ch.armed && ch.filt_dis && !ch.edge_both && !ch.edge_dir && ch.cmp_sync && !prev_r
        |-> ch.event_p;
    endproperty
    a_nofilt_rise: assert property (p_nofilt_rise) else $error("missed direct edge");

    property p_filt_hold;
        @(posedge clk) disable iff (reset)
        ce && !ch.tick |=> $stable(filt_r);
    endproperty
    a_filt_hold: assert property (p_filt_hold) else $error("filter moved without tick");

    c_filt_change: cover property (@(posedge clk) disable iff (reset) ce && filt_nxt != filt_r);
endmodule : cmpe_chan
`default_nettype wire

/* hw/cmpe_top.sv */
// cmpe_top: control registers, result monitor, output pins and interrupt
// requests for two independent comparators.
// assumes a plain register port on clk and digital comparator results from
// the analog section, which arrive asynchronously.
`default_nettype none
module cmpe_top
    import cmpe_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic soft_reset,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DW-1:0] rdata,
    input wire logic cmp1_analog_input,
    input wire logic cmp2_analog_input,
    input wire logic lowspeed_osc_clock,
    input wire logic wdt_detect,
    output logic comparator_result_out_pin1,
    output logic comparator_result_out_pin1_oe,
    output logic comparator_result_out_pin2,
    output logic comparator_result_out_pin2_oe,
    output logic cmp1_nmi_req,
    output logic cmp2_nmi_req,
    output logic cmp1_pending_request,
    output logic cmp2_pending_request,
    output logic [2:0] cmp1_priority_level,
    output logic [2:0] cmp2_priority_level,
    output logic ref_select_external,
    output logic cmp1_circuit_enable,
    output logic cmp2_circuit_enable,
    output logic cmp1_input_source_select,
    output logic cmp2_input_source_select,
    output logic comparator_pin_function_select,
    output logic lowspeed_osc_stop
);
    localparam int SW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [SW-1:0] SETTLE_END = SW'(SETTLE_CYCLES);

    logic [DW-1:0] ctrl_r [2];
    logic [DW-1:0] ctrl_nxt [2];
    logic [DW-1:0] ic_r [2];
    logic [DW-1:0] ic_nxt [2];
    logic [DW-1:0] det2_r, det2_nxt, src_r, src_nxt, edge_r, edge_nxt;
    logic [DW-1:0] mode_r, mode_nxt, pin_r, pin_nxt, clk1_r, clk1_nxt, ref_r, ref_nxt;
    logic [SW-1:0] settle_r [2];
    logic [SW-1:0] settle_nxt [2];
    logic [1:0] sy1_r, sy2_r, out_r, out_nxt, nmi_r, nmi_nxt;
    logic [1:0] ev, cfg_ok, ready, mon, en, srcsel, sel, pol, oe;
    logic [DW-1:0] rdata_r, rd_mux;
    logic tick1, tick2;

    cmpe_chan_if ch1_if ();
    cmpe_chan_if ch2_if ();

    // per-channel decoded fields; each path uses its own bits plus the shared pin function and oscillator stop bits
    assign en = {det2_r[DET2_EN2], det2_r[DET2_EN1]};
    assign srcsel = {src_r[SRC_CMP2], src_r[SRC_CMP1]};
    assign sel = {mode_r[MODE_SEL2], mode_r[MODE_SEL1]};
    assign pol = {mode_r[MODE_POL2], mode_r[MODE_POL1]};
    assign oe = {mode_r[MODE_OE2], mode_r[MODE_OE1]};
    assign ev = {ch2_if.event_p, ch1_if.event_p};

    // monitor shows the result once configured and settled
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            cfg_ok[i] = pin_r[PIN_COMP] & srcsel[i] & en[i];
            ready[i] = cfg_ok[i] && settle_r[i] == SETTLE_END;
            mon[i] = ready[i] & sy2_r[i];
            settle_nxt[i] = settle_r[i];
            if (!cfg_ok[i]) begin
                settle_nxt[i] = '0;
            end else if (!ready[i]) begin
                settle_nxt[i] = settle_r[i] + SW'(1);
            end
            out_nxt[i] = sy2_r[i] ^ pol[i];
        end
    end

    // channel configuration into the event channels
    assign ch1_if.cmp_sync = sy2_r[0];
    assign ch1_if.tick = tick1;
    assign ch1_if.filt_dis = ctrl_r[0][CB_FDIS];
    assign ch1_if.edge_both = edge_r[EDGE_BOTH1];
    assign ch1_if.edge_dir = ctrl_r[0][CB_DIR];
    assign ch1_if.armed = en[0] & ctrl_r[0][CB_IEN];
    assign ch2_if.cmp_sync = sy2_r[1];
    assign ch2_if.tick = tick2;
    assign ch2_if.filt_dis = ctrl_r[1][CB_FDIS];
    assign ch2_if.edge_both = edge_r[EDGE_BOTH2];
    assign ch2_if.edge_dir = ctrl_r[1][CB_DIR];
    assign ch2_if.armed = en[1] & ctrl_r[1][CB_IEN];

    cmpe_tick u_tick1 (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .osc_raw(lowspeed_osc_clock),
        .run(~clk1_r[CLK_OSC_STOP]),
        .div_sel(ctrl_r[0][CB_DIV+:2]),
        .tick(tick1)
    );
    cmpe_tick u_tick2 (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .osc_raw(lowspeed_osc_clock),
        .run(~clk1_r[CLK_OSC_STOP]),
        .div_sel(ctrl_r[1][CB_DIV+:2]),
        .tick(tick2)
    );
    cmpe_chan u_chan1 (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .ch(ch1_if.chan)
    );
    cmpe_chan u_chan2 (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .ch(ch2_if.chan)
    );

    // register writes, software reset, then hardware sets so a set wins
    always_comb begin
        ctrl_nxt = ctrl_r;
        ic_nxt = ic_r;
        det2_nxt = det2_r;
        src_nxt = src_r;
        edge_nxt = edge_r;
        mode_nxt = mode_r;
        pin_nxt = pin_r;
        clk1_nxt = clk1_r;
        ref_nxt = ref_r;
        nmi_nxt = 2'h0;
        if (wr_en) begin
            unique case (addr)
                // divider and filter-disable land in the same write
                ADR_CTRL1: ctrl_nxt[0] = {wdata[7], 1'b0, wdata[5:4], 1'b0,
                                          ctrl_r[0][CB_FLAG] & wdata[2], wdata[1:0]};
                ADR_CTRL2: ctrl_nxt[1] = {wdata[7], 1'b0, wdata[5:4],
                                          ctrl_r[1][3:2] & wdata[3:2], wdata[1:0]};
                ADR_DET2: det2_nxt = wdata & 8'hc0;
                ADR_SRC: src_nxt = wdata & 8'h60;
                ADR_EDGE: edge_nxt = wdata & 8'h06;
                ADR_MODE: mode_nxt = wdata & MODE_MASK;
                ADR_PIN: pin_nxt = wdata & 8'h01;
                ADR_CLK1: clk1_nxt = wdata & 8'h10;
                ADR_IC1: ic_nxt[0] = {4'h0, ic_r[0][IC_REQ] & wdata[3], wdata[2:0]};
                ADR_IC2: ic_nxt[1] = {4'h0, ic_r[1][IC_REQ] & wdata[3], wdata[2:0]};
                ADR_REF: ref_nxt = wdata & 8'h01;
                default: ;
            endcase
        end
        // software or watchdog reset spares the control register flags but clears the pending request bits
        if (soft_reset) begin
            ctrl_nxt[0] = (RST_CTRL & ~FLAG_MASK1) | (ctrl_r[0] & FLAG_MASK1);
            ctrl_nxt[1] = (RST_CTRL & ~FLAG_MASK2) | (ctrl_r[1] & FLAG_MASK2);
            ic_nxt[0] = RST_ZERO;
            ic_nxt[1] = RST_ZERO;
            det2_nxt = RST_ZERO;
            src_nxt = RST_ZERO;
            edge_nxt = RST_ZERO;
            mode_nxt = RST_ZERO;
            pin_nxt = RST_ZERO;
            clk1_nxt = RST_CLK1;
            ref_nxt = RST_ZERO;
        end
        for (int i = 0; i < 2; i++) begin
            if (ev[i]) begin
                ctrl_nxt[i][CB_FLAG] = 1'b1;
                if (sel[i]) begin
                    ic_nxt[i][IC_REQ] = 1'b1;
                end else begin
                    nmi_nxt[i] = 1'b1;
                end
            end
        end
        if (wdt_detect) begin
            ctrl_nxt[1][CB_B3] = 1'b1;
        end
    end

    // read mux; monitor bits are live state, reserved bits read zero
    always_comb begin
        unique case (addr)
            ADR_CTRL1: rd_mux = {ctrl_r[0][7:4], mon[0], ctrl_r[0][2:0]};
            ADR_CTRL2: rd_mux = ctrl_r[1];
            ADR_DET1: rd_mux = {4'h0, mon[1], 3'h0};
            ADR_DET2: rd_mux = det2_r;
            ADR_SRC: rd_mux = src_r;
            ADR_EDGE: rd_mux = edge_r;
            ADR_MODE: rd_mux = mode_r;
            ADR_PIN: rd_mux = pin_r;
            ADR_CLK1: rd_mux = clk1_r;
            ADR_IC1: rd_mux = ic_r[0];
            ADR_IC2: rd_mux = ic_r[1];
            ADR_REF: rd_mux = ref_r;
            default: rd_mux = 8'h00;
        endcase
    end

    // all state registers; synchronisers feed nothing but their second stage
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_r[0] <= RST_CTRL;
            ctrl_r[1] <= RST_CTRL;
            ic_r[0] <= RST_ZERO;
            ic_r[1] <= RST_ZERO;
            det2_r <= RST_ZERO;
            src_r <= RST_ZERO;
            edge_r <= RST_ZERO;
            mode_r <= RST_ZERO;
            pin_r <= RST_ZERO;
            clk1_r <= RST_CLK1;
            ref_r <= RST_ZERO;
            settle_r[0] <= '0;
            settle_r[1] <= '0;
            sy1_r <= 2'h0;
            sy2_r <= 2'h0;
            out_r <= 2'h0;
            nmi_r <= 2'h0;
            rdata_r <= 8'h00;
        end else if (ce) begin
            ctrl_r <= ctrl_nxt;
            ic_r <= ic_nxt;
            det2_r <= det2_nxt;
            src_r <= src_nxt;
            edge_r <= edge_nxt;
            mode_r <= mode_nxt;
            pin_r <= pin_nxt;
            clk1_r <= clk1_nxt;
            ref_r <= ref_nxt;
            settle_r <= settle_nxt;
            sy1_r <= {cmp2_analog_input, cmp1_analog_input};
            sy2_r <= sy1_r;
            out_r <= out_nxt;
            nmi_r <= nmi_nxt;
            rdata_r <= rd_en ? rd_mux : 8'h00;
        end
    end

    // port drive; pin enable needs the comparator pin function too
    assign rdata = rdata_r;
    assign comparator_result_out_pin1 = out_r[0];
    assign comparator_result_out_pin2 = out_r[1];
    assign comparator_result_out_pin1_oe = oe[0] & pin_r[PIN_COMP];
    assign comparator_result_out_pin2_oe = oe[1] & pin_r[PIN_COMP];
    assign cmp1_nmi_req = nmi_r[0];
    assign cmp2_nmi_req = nmi_r[1];
    assign cmp1_pending_request = ic_r[0][IC_REQ];
    assign cmp2_pending_request = ic_r[1][IC_REQ];
    assign cmp1_priority_level = ic_r[0][2:0];
    assign cmp2_priority_level = ic_r[1][2:0];
    assign ref_select_external = ref_r[REF_EXT];
    assign cmp1_circuit_enable = en[0];
    assign cmp2_circuit_enable = en[1];
    assign cmp1_input_source_select = srcsel[0];
    assign cmp2_input_source_select = srcsel[1];
    assign comparator_pin_function_select = pin_r[PIN_COMP];
    assign lowspeed_osc_stop = clk1_r[CLK_OSC_STOP];

    property p_mon_wait;
        @(posedge clk) disable iff (reset)
        ce && !cfg_ok[0] |=> !mon[0] && settle_r[0] == '0;
    endproperty
    a_mon_wait: assert property (p_mon_wait) else $error("monitor before settling");

    property p_mon2_follow;
        @(posedge clk) disable iff (reset)
        cfg_ok[1] && settle_r[1] == SETTLE_END |-> mon[1] == sy2_r[1];
    endproperty
    a_mon2_follow: assert property (p_mon2_follow) else $error("monitor2 wrong");

    property p_nmi1;
        @(posedge clk) disable iff (reset)
        ce && ev[0] && !sel[0] |=> cmp1_nmi_req && ctrl_r[0][CB_FLAG];
    endproperty
    a_nmi1: assert property (p_nmi1) else $error("no nmi on cmp1 event");

    property p_ir2;
        @(posedge clk) disable iff (reset)
        ce && ev[1] && sel[1] |=> cmp2_pending_request && !cmp2_nmi_req && ctrl_r[1][CB_FLAG];
    endproperty
    a_ir2: assert property (p_ir2) else $error("no pending bit on cmp2 event");

    property p_flag_w1;
        @(posedge clk) disable iff (reset)
        ce && wr_en && addr == ADR_CTRL1 && wdata[CB_FLAG] && !ctrl_r[0][CB_FLAG] && !ev[0]
        |=> !ctrl_r[0][CB_FLAG];
    endproperty
    a_flag_w1: assert property (p_flag_w1) else $error("flag set by software");

    property p_flag_w0;
        @(posedge clk) disable iff (reset)
        ce && wr_en && addr == ADR_CTRL2 && !wdata[CB_FLAG] && !ev[1] |=> !ctrl_r[1][CB_FLAG];
    endproperty
    a_flag_w0: assert property (p_flag_w0) else $error("flag clear lost");

    property p_soft_keep;
        @(posedge clk) disable iff (reset)
        ce && soft_reset && ctrl_r[1][CB_FLAG] && ctrl_r[1][CB_B3] |=> ctrl_r[1][3:2] == 2'h3;
    endproperty
    a_soft_keep: assert property (p_soft_keep) else $error("flag lost on soft reset");

    property p_indep;
        @(posedge clk) disable iff (reset)
        ce && ev[0] && !ev[1] && !ctrl_r[1][CB_FLAG] |=> !ctrl_r[1][CB_FLAG] && !cmp2_nmi_req;
    endproperty
    a_indep: assert property (p_indep) else $error("channel crosstalk");

    property p_out_pol;
        @(posedge clk) disable iff (reset)
        ce |=> comparator_result_out_pin2 == ($past(sy2_r[1]) ^ $past(pol[1]));
    endproperty
    a_out_pol: assert property (p_out_pol) else $error("output polarity wrong");

    c_nmi1: cover property (@(posedge clk) disable iff (reset) cmp1_nmi_req);
    c_ir2: cover property (@(posedge clk) disable iff (reset) $rose(cmp2_pending_request));
    c_mon1: cover property (@(posedge clk) disable iff (reset) mon[0]);
endmodule : cmpe_top
`default_nettype wire

/* tb/cmpe_analog_model.sv */
// cmpe_analog_model: far side of both comparators, result levels and oscillator.
// assumes the bench sets the compared levels; the oscillator runs free.
`default_nettype none
module cmpe_analog_model (
    input wire logic lvl1,
    input wire logic lvl2,
    output logic res1,
    output logic res2,
    output var logic osc
);
    timeunit 1ns;
    timeprecision 1ns;
    // free-running, period of 34 clk cycles
    initial osc = 1'b0;
    always #1700 osc = ~osc;
    // results follow the compared levels
    assign res1 = lvl1;
    assign res2 = lvl2;
endmodule : cmpe_analog_model
`default_nettype wire

/* tb/tb_cmpe_top.sv */
// tb_cmpe_top: register-driven tests of the dual comparator event block.
// assumes the design package and a 10 MHz clock; ce is tied high.
`default_nettype none
module tb_cmpe_top
    import cmpe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, reset = 1'b1, soft_reset = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic [AW-1:0] addr = 4'h0;
    logic [DW-1:0] wdata = 8'h00, rdata, d;
    logic lvl1 = 1'b0, lvl2 = 1'b0, a1, a2, osc, pin1, oe1, nmi1, nmi2, pend1, pend2, refx;
    logic wdt = 1'b0, pin2, oe2, cen1, cen2, s1, s2, pinf, ostop;
    logic [2:0] lev1, lev2;
    int errors = 0, n_tests = 0, hits, t;
    cmpe_analog_model u_cmpe_analog_model (.lvl1, .lvl2, .res1(a1), .res2(a2), .osc);
    cmpe_top #(.SETTLE_CYCLES(4)) u_cmpe_top (.clk, .reset, .ce(1'b1), .soft_reset,
        .addr, .wdata, .wr_en, .rd_en, .rdata, .cmp1_analog_input(a1),
        .cmp2_analog_input(a2), .lowspeed_osc_clock(osc), .wdt_detect(wdt),
        .comparator_result_out_pin1(pin1), .comparator_result_out_pin1_oe(oe1),
        .comparator_result_out_pin2(pin2), .comparator_result_out_pin2_oe(oe2),
        .cmp1_nmi_req(nmi1), .cmp2_nmi_req(nmi2), .cmp1_pending_request(pend1),
        .cmp2_pending_request(pend2), .cmp1_priority_level(lev1),
        .cmp2_priority_level(lev2), .ref_select_external(refx),
        .cmp1_circuit_enable(cen1), .cmp2_circuit_enable(cen2),
        .cmp1_input_source_select(s1), .cmp2_input_source_select(s2),
        .comparator_pin_function_select(pinf), .lowspeed_osc_stop(ostop));
    always #50 clk = ~clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask : rd
    task automatic chk(input string n, input logic [DW-1:0] e, input logic [DW-1:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rchk(input string n, input logic [AW-1:0] a, input logic [DW-1:0] e);
        rd(a, d);
        chk(n, e, d);
    endtask : rchk
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // hang guard, well beyond the sequence below
    initial begin
        cyc(5000);
        errors++;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rchk("ctrl1", ADR_CTRL1, RST_CTRL);
        rchk("clk1", ADR_CLK1, RST_CLK1);
        lvl1 <= 1'b1;
        wr(ADR_PIN, 8'h01);
        wr(ADR_SRC, 8'h20);
        wr(ADR_DET2, 8'h40);
        cyc(12);
        rchk("mon1", ADR_CTRL1, 8'h0a);
        wr(ADR_MODE, 8'h05);
        cyc(3);
        chk("pin1", 8'h02, {6'h00, oe1, pin1});
        wr(ADR_MODE, 8'h04);
        wr(ADR_REF, 8'h01);
        cyc(3);
        chk("pin1ref", 8'h07, {5'h00, refx, oe1, pin1});
        lvl1 <= 1'b0;
        wr(ADR_MODE, 8'h00);
        wr(ADR_CTRL1, 8'h02);
        wr(ADR_EDGE, 8'h00);
        wr(ADR_CTRL1, 8'h02);
        wr(ADR_CTRL1, 8'h03);
        lvl1 <= 1'b1;
        hits = 0;
        repeat (10) begin
            cyc(1);
            if (nmi1 === 1'b1) hits++;
        end
        chk("nmi1", 8'h01, hits[7:0]);
        rchk("flag1", ADR_CTRL1, 8'h0f);
        rchk("ctrl2", ADR_CTRL2, RST_CTRL);
        wr(ADR_CTRL1, 8'h07);
        rchk("flag1", ADR_CTRL1, 8'h0f);
        // watchdog flag first, so the soft reset has two flags to spare
        @(posedge clk);
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        rchk("flagkeep", ADR_CTRL1, 8'h06);
        rchk("wdtkeep", ADR_CTRL2, 8'h0a);
        wr(ADR_CTRL1, 8'h02);
        rchk("flagclr", ADR_CTRL1, 8'h02);
        wr(ADR_CTRL1, 8'h06);
        rchk("flagw1", ADR_CTRL1, 8'h02);
        lvl2 <= 1'b1;
        wr(ADR_PIN, 8'h01);
        wr(ADR_SRC, 8'h40);
        wr(ADR_DET2, 8'h80);
        cyc(12);
        rd(ADR_DET1, d);
        chk("mon2", 8'h08, d & 8'h08);
        chk("cfg", 8'h17, {2'h0, cen1, cen2, s1, s2, pinf, ostop});
        lvl2 <= 1'b0;
        wr(ADR_MODE, 8'h2a);
        wr(ADR_CTRL2, 8'h30);
        wr(ADR_CLK1, 8'h00);
        cyc(600);
        wr(ADR_CTRL2, 8'h31);
        wr(ADR_IC2, 8'h05);
        lvl2 <= 1'b1;
        cyc(30);
        chk("filt", 8'h00, {7'h00, pend2});
        // three agreeing samples at osc/8 (272 cycles each): 540 to 830 after the change
        for (t = 0; t < 900 && pend2 !== 1'b1; t++) cyc(1);
        chk("ticks", 8'h01, {7'h00, 30 + t >= 540 && 30 + t <= 830});
        chk("pend2", 8'h0d, {4'h0, pend2, lev2});
        chk("other", 8'h00, {3'h0, lev1, pend1, nmi2});
        chk("pin2", 8'h02, {6'h00, oe2, pin2});
        rchk("flag2", ADR_CTRL2, 8'h35);
        tally_and_finish;
    end
endmodule : tb_cmpe_top
`default_nettype wire
